/* File: pkg/npiu_params.svh */
// register offsets, field positions, reset values and vector constants for the interrupt unit
`ifndef NPIU_PARAMS_SVH
`define NPIU_PARAMS_SVH

`define NPIU_ADDR_W          4
`define NPIU_DATA_W          16

`define NPIU_REG_MASK        4'h0
`define NPIU_REG_NEST        4'h1
`define NPIU_REG_INSERV      4'h2
`define NPIU_REG_STATUS      4'h3
`define NPIU_REG_LEVEL_LO    4'h4
`define NPIU_REG_LEVEL_HI    4'h5
`define NPIU_REG_SWITCH_EN   4'h6
`define NPIU_REG_MACRO_SEL   4'h7
`define NPIU_REG_REQ_FLAGS   4'h8
`define NPIU_REG_WDOG_MODE   4'h9

`define NPIU_NEST_EN_BIT     7
`define NPIU_IE_BIT          5
`define NPIU_ORDER_BIT       0

`define NPIU_RST_MASK        16'hffff
`define NPIU_RST_NEST_EN     1'b1
`define NPIU_RST_INSERV      4'h0
`define NPIU_RST_STATUS      8'h00
`define NPIU_RST_LEVEL       32'hffffffff
`define NPIU_RST_SWITCH_EN   16'h0000
`define NPIU_RST_MACRO_SEL   16'h0000
`define NPIU_RST_FLAGS       16'h0000
`define NPIU_RST_ORDER       1'b0

`define NPIU_VEC_NMI_PIN     16'h0002
`define NPIU_VEC_NMI_WDT     16'h0004
`define NPIU_VEC_BASE        16'h0006
`define NPIU_LOWEST_LEVEL    2'h3

`endif

/* File: pkg/npiu_pkg.sv */
// types shared by the interrupt unit modules
package npiu_pkg;

  typedef enum logic [2:0] {
    KIND_NONE     = 3'b000,
    KIND_NMI_PIN  = 3'b001,
    KIND_NMI_WDT  = 3'b010,
    KIND_VECTORED = 3'b011,
    KIND_SWITCHED = 3'b100,
    KIND_MACRO    = 3'b101
  } npiu_kind_t;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_WAIT = 1'b1
  } npiu_phase_t;

  // one acceptance handed to the core sequencer
  typedef struct packed {
    logic        valid;
    npiu_kind_t  kind;
    logic [3:0]  src;
    logic [1:0]  level;
    logic [2:0]  bank;
    logic [15:0] vec_addr;
  } npiu_accept_t;

  // one-cycle pulses from the core sequencer
  typedef struct packed {
    logic       boundary;
    logic       done;
    logic       ret_vectored;
    logic       ret_break;
    logic       ret_switched;
    logic       ret_soft_switched;
    logic       pop_status;
    logic       soft_trap;
    logic       soft_switch_trap;
    logic       irq_on;
    logic       irq_off;
    logic [7:0] status_in;
  } npiu_core_evt_t;

  typedef struct packed {
    logic [15:0]  mask;
    logic         nest_en;
    logic [3:0]   inserv;
    logic [7:0]   status;
    logic [31:0]  level;
    logic [15:0]  switch_en;
    logic [15:0]  macro_sel;
    logic [15:0]  flags;
    logic         order;
    logic [2:0]   nmi_sync;
    logic         nmi_lvl;
    logic [1:0]   nmi_act;
    logic [1:0]   nmi_pend;
    npiu_phase_t  phase;
    npiu_accept_t acc;
    logic [15:0]  rdata;
  } npiu_state_t;

endpackage

/* File: src/npiu_level_pick.sv */
// picks the request with the best programmed level, lowest index breaking ties
`timescale 1ns/1ns
`default_nettype none

module npiu_level_pick #(
  parameter int N = 16
) (
  // candidates
  input  wire logic [N-1:0]   vec,
  input  wire logic [2*N-1:0] lvl,
  // winner
  output logic                found,
  output logic [3:0]          idx,
  output logic [1:0]          level
);

  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    level = 2'h3;
    // strict compare keeps the earliest index on equal levels: default order
    for (int i = 0; i < N; i++) begin
      if (vec[i] && (!found || lvl[2*i +: 2] < level)) begin
        found = 1'b1;
        idx   = i[3:0];
        level = lvl[2*i +: 2];
      end
    end
  end

endmodule

`default_nettype wire

/* File: src/npiu_top.sv */
// nested priority interrupt unit: masking, nesting, non-maskable arbitration and entry control
//
// Operation
// R1: mask bit 0 gates timer-3 overflow, bit 15 gates converter end, sources in order.
// R2: level-3 request nests over level-3 service only with nest enable set.
// R3: same-level nesting never allowed for levels 0, 1 and 2.
// R4: nesting control bits 6..0 always read zero; only bit 7 stores.
// R5: nest enable resets to one; software may change it afterwards.
// R6: vectored or switch return clears only the highest set in-service bit.
// R7: break return and soft switch return leave in-service bits alone.
// R8: in-service register resets to zero, is read-only, upper bits zero.
// R9: vectored entry or soft trap clears enable; returns and pop restore status.
// R10: switch entry clears enable; switch returns reload status from the bank.
// R11: non-maskable and macro requests ignore enable; macro leaves enable unchanged.
// R12: low status byte including enable resets to zero.
// R13: order bit 1 ranks watchdog non-maskable above pin, 0 below.
// R14: same or lower non-maskable held pending, taken after return, repeats collapse.
// R15: non-maskable entry pushes status then pc, clears enable, vectors.
// R16: macro requests still accepted during a non-maskable service.
// R17: request needs flag set, mask clear; vectored also needs enable and priority.
// R18: best level first, default order on ties, held requests taken later.
// R19: vectored entry pushes, clears enable, sets in-service bit, loads vector.
// R20: switch entry selects bank from low three bits of vector address.
// R21: switch entry loads pc from bank while saving pc and status there.
// R22: switch return reloads pc and status from bank, clears highest bit.
// R23: two-bit level, 0 highest, 3 lowest, levels may be shared.
// R24: request flag set by its request, cleared by hardware on acceptance.
// R25: decisions only at instruction boundaries; core finishes before next arbitration.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "npiu_params.svh"

module npiu_top #(
  parameter int          N_SRC    = 16,
  parameter logic [15:0] VEC_BASE = `NPIU_VEC_BASE
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // register port
  input  wire logic [`NPIU_ADDR_W-1:0]       reg_addr,
  input  wire logic [`NPIU_DATA_W-1:0]       reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [`NPIU_DATA_W-1:0]       reg_rdata,
  // interrupt sources
  input  wire logic [N_SRC-1:0]              src_req,
  input  wire logic                          nmi_pin,
  input  wire logic                          wdt_nmi_req,
  // core sequencer
  input  wire npiu_pkg::npiu_core_evt_t      core_evt,
  output npiu_pkg::npiu_accept_t             accept,
  output logic      [7:0]                    status_word_low,
  output logic      [3:0]                    in_service_levels,
  output logic                               global_irq_enable
);

  npiu_pkg::npiu_state_t st_r;
  npiu_pkg::npiu_state_t st_nxt;

  // candidate masks
  logic [N_SRC-1:0] pending_unmasked;
  logic [N_SRC-1:0] macro_cand;
  logic [N_SRC-1:0] vect_cand;
  logic             mac_found;
  logic [3:0]       mac_idx;
  logic [1:0]       mac_lvl;
  logic             vec_found;
  logic [3:0]       vec_idx;
  logic [1:0]       vec_lvl;

  assign pending_unmasked = st_r.flags & ~st_r.mask; // R17 R1
  assign macro_cand       = pending_unmasked & st_r.macro_sel;
  assign vect_cand        = pending_unmasked & ~st_r.macro_sel;

  npiu_level_pick #(
    .N     (N_SRC)
  ) u_pick_macro (
    .vec   (macro_cand),
    .lvl   (st_r.level),
    .found (mac_found),
    .idx   (mac_idx),
    .level (mac_lvl)
  );

  npiu_level_pick #(
    .N     (N_SRC)
  ) u_pick_vect (
    .vec   (vect_cand),
    .lvl   (st_r.level),
    .found (vec_found),
    .idx   (vec_idx),
    .level (vec_lvl)
  );

  // in-service bits at or above a given level (lower number is higher)
  function automatic logic [3:0] at_or_above(input logic [1:0] lv);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (i[1:0] <= lv) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // keep only the lowest set bit, which is the highest level in service
  function automatic logic [3:0] top_bit(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction

  logic       nmi_edge;
  logic       nmi_filt;
  logic       wdt_first;
  logic       pin_ok;
  logic       wdt_ok;
  logic       level_ok;
  logic [15:0] vec_addr;
  logic [2:0]  bank_sel;

  always_comb begin
    logic [3:0]  isr_clr;
    logic [15:0] flag_clr;
    logic [1:0]  nmi_clr;
    logic [1:0]  nmi_new;
    logic        take;

    isr_clr  = 4'h0;
    flag_clr = 16'h0000;
    nmi_clr  = 2'b00;
    nmi_new  = 2'b00;
    take     = 1'b0;
    st_nxt   = st_r;
    st_nxt.acc.valid = 1'b0;
    st_nxt.rdata     = 16'h0000;

    // pin: three stages, a change counts once stages two and three agree
    st_nxt.nmi_sync = {st_r.nmi_sync[1:0], nmi_pin};
    nmi_filt = (st_r.nmi_sync[1] == st_r.nmi_sync[2]) ? st_r.nmi_sync[2] : st_r.nmi_lvl;
    st_nxt.nmi_lvl = nmi_filt;
    nmi_edge = nmi_filt & ~st_r.nmi_lvl;
    nmi_new  = {wdt_nmi_req, nmi_edge};

    // index 0 is the pin, index 1 the watchdog
    wdt_first = st_r.order; // R13
    pin_ok = st_r.nmi_pend[0] && !st_r.nmi_act[0] && !(st_r.nmi_act[1] && wdt_first); // R14
    wdt_ok = st_r.nmi_pend[1] && !st_r.nmi_act[1] && !(st_r.nmi_act[0] && !wdt_first); // R14

    // nesting: no in-service bit at or above the new level, except level 3 over 3
    level_ok = ((st_r.inserv & at_or_above(vec_lvl)) == 4'h0) // R3
            || (vec_lvl == `NPIU_LOWEST_LEVEL && st_r.inserv[2:0] == 3'b000
                && st_r.nest_en); // R2

    vec_addr = VEC_BASE + {11'h000, vec_idx, 1'b0};
    bank_sel = vec_addr[2:0]; // R20

    // arbitration only at a boundary and only once the core closed the last entry
    if (st_r.phase == npiu_pkg::PH_IDLE && core_evt.boundary) begin // R25
      if (pin_ok && (!wdt_ok || !wdt_first)) begin // R13
        take = 1'b1;
        st_nxt.acc.kind     = npiu_pkg::KIND_NMI_PIN;
        st_nxt.acc.vec_addr = `NPIU_VEC_NMI_PIN;
        st_nxt.acc.src      = 4'h0;
        st_nxt.acc.level    = 2'h0;
        st_nxt.acc.bank     = 3'h0;
        nmi_clr[0]          = 1'b1;
        st_nxt.nmi_act[0]   = 1'b1;
        st_nxt.status[`NPIU_IE_BIT] = 1'b0; // R15 R11
      end else if (wdt_ok) begin
        take = 1'b1;
        st_nxt.acc.kind     = npiu_pkg::KIND_NMI_WDT;
        st_nxt.acc.vec_addr = `NPIU_VEC_NMI_WDT;
        st_nxt.acc.src      = 4'h0;
        st_nxt.acc.level    = 2'h0;
        st_nxt.acc.bank     = 3'h0;
        nmi_clr[1]          = 1'b1;
        st_nxt.nmi_act[1]   = 1'b1;
        st_nxt.status[`NPIU_IE_BIT] = 1'b0; // R15 R11
      end else if (mac_found) begin // R11 R16 R17
        // macro service leaves the enable bit as it is
        take = 1'b1;
        st_nxt.acc.kind     = npiu_pkg::KIND_MACRO;
        st_nxt.acc.src      = mac_idx;
        st_nxt.acc.level    = mac_lvl;
        st_nxt.acc.bank     = 3'h0;
        st_nxt.acc.vec_addr = VEC_BASE + {11'h000, mac_idx, 1'b0};
        flag_clr[mac_idx]   = 1'b1; // R24
      end else if (vec_found && st_r.status[`NPIU_IE_BIT] && level_ok) begin // R17 R18
        take = 1'b1;
        st_nxt.acc.src      = vec_idx;
        st_nxt.acc.level    = vec_lvl; // R23
        flag_clr[vec_idx]   = 1'b1; // R24
        st_nxt.inserv       = st_r.inserv | (4'h1 << vec_lvl); // R19
        st_nxt.status[`NPIU_IE_BIT] = 1'b0; // R19 R10
        if (st_r.switch_en[vec_idx]) begin
          // core reads pc from the bank and stores pc and status there in one step
          st_nxt.acc.kind     = npiu_pkg::KIND_SWITCHED; // R21
          st_nxt.acc.bank     = bank_sel; // R20
          st_nxt.acc.vec_addr = vec_addr;
        end else begin
          st_nxt.acc.kind     = npiu_pkg::KIND_VECTORED;
          st_nxt.acc.bank     = 3'h0;
          st_nxt.acc.vec_addr = vec_addr;
        end
      end
    end

    if (take) begin
      st_nxt.acc.valid = 1'b1;
      st_nxt.phase     = npiu_pkg::PH_WAIT;
    end else if (st_r.phase == npiu_pkg::PH_WAIT && core_evt.done) begin // R25
      st_nxt.phase = npiu_pkg::PH_IDLE;
    end

    // core instructions acting on the status byte and in-service bits
    if (core_evt.irq_on) begin
      st_nxt.status[`NPIU_IE_BIT] = 1'b1;
    end
    if (core_evt.irq_off) begin
      st_nxt.status[`NPIU_IE_BIT] = 1'b0;
    end
    if (core_evt.soft_trap || core_evt.soft_switch_trap) begin
      st_nxt.status[`NPIU_IE_BIT] = 1'b0; // R9 R10
    end
    if (core_evt.ret_vectored || core_evt.ret_break || core_evt.pop_status) begin
      st_nxt.status = core_evt.status_in; // R9
    end
    if (core_evt.ret_switched || core_evt.ret_soft_switched) begin
      st_nxt.status = core_evt.status_in; // R10 R22
    end
    if (core_evt.ret_vectored && st_r.nmi_act != 2'b00) begin
      // a nested pair ends inner first: the higher-ranked one is the inner
      if (st_r.nmi_act == 2'b11) begin
        st_nxt.nmi_act = wdt_first ? 2'b01 : 2'b10; // R14
      end else begin
        st_nxt.nmi_act = 2'b00; // R14
      end
    end else if (core_evt.ret_vectored || core_evt.ret_switched) begin
      isr_clr = top_bit(st_r.inserv); // R6 R22
    end
    // break return and soft switch return never touch the in-service bits R7

    // software register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `NPIU_REG_MASK:      st_nxt.mask      = reg_wdata; // R1
        `NPIU_REG_NEST:      st_nxt.nest_en   = reg_wdata[`NPIU_NEST_EN_BIT]; // R4 R5
        `NPIU_REG_STATUS:    st_nxt.status    = reg_wdata[7:0];
        `NPIU_REG_LEVEL_LO:  st_nxt.level[15:0]  = reg_wdata;
        `NPIU_REG_LEVEL_HI:  st_nxt.level[31:16] = reg_wdata;
        `NPIU_REG_SWITCH_EN: st_nxt.switch_en = reg_wdata;
        `NPIU_REG_MACRO_SEL: st_nxt.macro_sel = reg_wdata;
        `NPIU_REG_REQ_FLAGS: st_nxt.flags     = reg_wdata;
        `NPIU_REG_WDOG_MODE: st_nxt.order     = reg_wdata[`NPIU_ORDER_BIT];
        // in-service register and unmapped offsets ignore writes R8
        default: ;
      endcase
    end

    // hardware set beats clear in the same cycle for flags and pending; in-service clear beats set
    st_nxt.flags    = (st_nxt.flags & ~flag_clr) | src_req[15:0]; // R24
    st_nxt.nmi_pend = (st_r.nmi_pend & ~nmi_clr) | nmi_new; // R14
    st_nxt.inserv   = st_nxt.inserv & ~isr_clr;

    if (reg_rd) begin
      unique case (reg_addr)
        `NPIU_REG_MASK:      st_nxt.rdata = st_r.mask;
        `NPIU_REG_NEST:      st_nxt.rdata = {8'h00, st_r.nest_en, 7'h00}; // R4
        `NPIU_REG_INSERV:    st_nxt.rdata = {12'h000, st_r.inserv}; // R8
        `NPIU_REG_STATUS:    st_nxt.rdata = {8'h00, st_r.status};
        `NPIU_REG_LEVEL_LO:  st_nxt.rdata = st_r.level[15:0];
        `NPIU_REG_LEVEL_HI:  st_nxt.rdata = st_r.level[31:16];
        `NPIU_REG_SWITCH_EN: st_nxt.rdata = st_r.switch_en;
        `NPIU_REG_MACRO_SEL: st_nxt.rdata = st_r.macro_sel;
        `NPIU_REG_REQ_FLAGS: st_nxt.rdata = st_r.flags;
        `NPIU_REG_WDOG_MODE: st_nxt.rdata = {15'h0000, st_r.order};
        default:             st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r.mask      <= `NPIU_RST_MASK;
      st_r.nest_en   <= `NPIU_RST_NEST_EN; // R5
      st_r.inserv    <= `NPIU_RST_INSERV; // R8
      st_r.status    <= `NPIU_RST_STATUS; // R12
      st_r.level     <= `NPIU_RST_LEVEL;
      st_r.switch_en <= `NPIU_RST_SWITCH_EN;
      st_r.macro_sel <= `NPIU_RST_MACRO_SEL;
      st_r.flags     <= `NPIU_RST_FLAGS;
      st_r.order     <= `NPIU_RST_ORDER;
      st_r.nmi_sync  <= 3'b000;
      st_r.nmi_lvl   <= 1'b0;
      st_r.nmi_act   <= 2'b00;
      st_r.nmi_pend  <= 2'b00;
      st_r.phase     <= npiu_pkg::PH_IDLE;
      st_r.acc       <= '0;
      st_r.rdata     <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata         = st_r.rdata;
  assign accept            = st_r.acc;
  assign status_word_low   = st_r.status;
  assign in_service_levels = st_r.inserv;
  assign global_irq_enable = st_r.status[`NPIU_IE_BIT];

endmodule

`default_nettype wire

/* File: testbench/npiu_top_sva.sv */
// port-level assertion checker for the interrupt unit
`timescale 1ns/1ns
`default_nettype none
module npiu_top_sva #(
  parameter logic [15:0] VEC_BASE = 16'h0006
) (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst,
  // register port
  input wire logic [3:0]               reg_addr,
  input wire logic                     reg_rd,
  input wire logic [15:0]              reg_rdata,
  // core side
  input wire npiu_pkg::npiu_core_evt_t core_evt,
  input wire npiu_pkg::npiu_accept_t   accept,
  input wire logic [7:0]               status_word_low,
  input wire logic [3:0]               in_service_levels,
  input wire logic                     global_irq_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_accept_one_cycle: assert property (accept.valid |=> !accept.valid)
    else $error("accept valid held past one cycle");
  a_entry_ie_off: assert property (accept.valid && accept.kind != npiu_pkg::KIND_MACRO |-> !global_irq_enable)
    else $error("enable still set after entry");
  a_macro_keeps_ie: assert property (accept.valid && accept.kind == npiu_pkg::KIND_MACRO |-> global_irq_enable == $past(global_irq_enable))
    else $error("macro acceptance changed enable");
  a_vec_map: assert property (accept.valid && accept.kind == npiu_pkg::KIND_VECTORED |-> accept.vec_addr == VEC_BASE + {11'h0, accept.src, 1'b0})
    else $error("vector address does not match source");
  a_level_marked: assert property (accept.valid && accept.kind == npiu_pkg::KIND_VECTORED |-> in_service_levels[accept.level])
    else $error("in-service bit of accepted level not set");
  a_bank_pick: assert property (accept.valid && accept.kind == npiu_pkg::KIND_SWITCHED |-> accept.bank == accept.vec_addr[2:0])
    else $error("bank not taken from vector address");
  a_break_keeps: assert property ((core_evt.ret_break || core_evt.ret_soft_switched) && !core_evt.boundary |=> $stable(in_service_levels))
    else $error("in-service bits changed by break return");
  a_ret_top_clear: assert property (core_evt.ret_switched && !core_evt.boundary |=> in_service_levels == ($past(in_service_levels) & ($past(in_service_levels) - 4'h1)))
    else $error("switch return did not clear only the top bit");
  a_nest_read: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[6:0] == 7'h0 && reg_rdata[15:8] == 8'h0)
    else $error("nest control low bits read nonzero");
  a_inserv_read: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata == {12'h0, $past(in_service_levels)})
    else $error("in-service read data wrong");
  a_reset_clear: assert property (@(posedge ref_clk) disable iff (1'b0) rst |-> status_word_low == 8'h00 && in_service_levels == 4'h0)
    else $error("status or in-service not cleared in reset");
endmodule

bind npiu_top npiu_top_sva #(.VEC_BASE(VEC_BASE)) u_sva (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_evt(core_evt), .accept(accept), .status_word_low(status_word_low),
  .in_service_levels(in_service_levels), .global_irq_enable(global_irq_enable)
);
`default_nettype wire

/* File: testbench/npiu_core_model.sv */
// behavioural core sequencer facing the unit's accept/done handshake
`timescale 1ns/1ns
`default_nettype none
module npiu_core_model (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // bench control
  input  wire logic                   run,
  input  wire logic                   slow,
  // unit side
  input  wire npiu_pkg::npiu_accept_t accept,
  output logic                        boundary,
  output logic                        done
);
  int gap;
  int busy;
  // no boundary while a save/vector sequence is still running
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boundary <= 1'b0;
      done     <= 1'b0;
      gap = 0;
      busy = -1;
    end else begin
      boundary <= 1'b0;
      done     <= 1'b0;
      if (accept.valid === 1'b1)
        busy = slow ? 5 : 0;
      if (busy == 0)
        done <= 1'b1;
      if (busy >= 0)
        busy--;
      else if (run) begin
        gap++;
        boundary <= (gap % 3 == 0);
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_nested_priority_interrupt_unit.sv */
// self-checking bench for the nested priority interrupt unit
`timescale 1ns/1ns
`default_nettype none
module test_nested_priority_interrupt_unit;
  localparam logic [2:0] NON = npiu_pkg::KIND_NONE;
  localparam logic [2:0] PIN = npiu_pkg::KIND_NMI_PIN;
  localparam logic [2:0] WDT = npiu_pkg::KIND_NMI_WDT;
  localparam logic [2:0] VEC = npiu_pkg::KIND_VECTORED;
  localparam logic [2:0] SWC = npiu_pkg::KIND_SWITCHED;
  localparam logic [2:0] MAC = npiu_pkg::KIND_MACRO;
  // bit positions inside the packed core event word
  localparam int RV = 16, RB = 15, RS = 14, POP = 12, ON = 9;
  logic                     ref_clk, rst, reg_wr, reg_rd, nmi_pin, wdt_nmi_req;
  logic                     run, slow, boundary, done, global_irq_enable;
  logic [3:0]               reg_addr, in_service_levels;
  logic [7:0]               status_word_low;
  logic [15:0]              reg_wdata, reg_rdata, src_req, rd;
  logic [15:0]              rv [11];
  npiu_pkg::npiu_core_evt_t evt, core_evt;
  npiu_pkg::npiu_accept_t   accept;
  int                       errors, n_tests, i, a, lv, ne, k;

  npiu_top dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .nmi_pin(nmi_pin),
    .wdt_nmi_req(wdt_nmi_req), .core_evt(core_evt), .accept(accept),
    .status_word_low(status_word_low), .in_service_levels(in_service_levels),
    .global_irq_enable(global_irq_enable)
  );
  npiu_core_model u_core (
    .ref_clk(ref_clk), .rst(rst), .run(run), .slow(slow), .accept(accept),
    .boundary(boundary), .done(done)
  );

  // boundary and done come from the sequencer model, the rest from the bench
  always_comb begin
    core_evt = evt;
    core_evt.boundary = boundary;
    core_evt.done = done;
  end

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // every driving task starts on a rising edge and returns at the falling edge
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rdr(input logic [3:0] ad, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic pulse(input logic [15:0] m);
    @(posedge ref_clk);
    src_req <= m;
    @(posedge ref_clk);
    src_req <= 16'h0;
    @(negedge ref_clk);
  endtask

  task automatic fire(input int b, input logic [7:0] st);
    @(posedge ref_clk);
    evt <= npiu_pkg::npiu_core_evt_t'((19'h1 << b) | {11'h0, st});
    @(posedge ref_clk);
    evt <= '0;
    @(negedge ref_clk);
  endtask

  task automatic expect_acc(input logic [2:0] kd, input logic [15:0] v, input int n);
    int j;
    for (j = 0; j < n; j++) begin
      @(negedge ref_clk);
      if (accept.valid === 1'b1)
        break;
    end
    chk({15'h0, j < n}, {15'h0, kd != NON});
    if (kd != NON && j < n) begin
      chk({13'h0, accept.kind}, {13'h0, kd});
      chk(accept.vec_addr, v);
    end
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, nmi_pin, wdt_nmi_req, run, slow} = 6'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    src_req = 16'h0;
    evt = '0;
    errors = 0;
    n_tests = 0;
    void'($urandom(32'h9f705bc0));
    rv = '{16'hffff, 16'h0080, 16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 11; i++) begin
      rdr(i[3:0], rd);
      chk(rd, rv[i]);
    end
    wr(4'h1, 16'h00ff);
    rdr(4'h1, rd);
    chk(rd, 16'h0080);
    wr(4'h1, 16'h007f);
    rdr(4'h1, rd);
    chk(rd, 16'h0000);
    wr(4'h2, 16'h000f);
    rdr(4'h2, rd);
    chk(rd, 16'h0000);
    run <= 1'b1;
    // same-level nesting for every level, with and without the level-3 enable
    for (lv = 0; lv < 4; lv++) for (ne = 0; ne < 2; ne++) begin
      a = $urandom_range(7, 0);
      wr(4'h4, {8{lv[1:0]}});
      wr(4'h5, {8{lv[1:0]}});
      wr(4'h1, {8'h0, ne[0], 7'h0});
      wr(4'h0, ~(16'h0101 << a));
      fire(ON, 8'h0);
      pulse(16'h1 << a);
      expect_acc(VEC, 16'(6 + 2 * a), 40);
      chk({12'h0, in_service_levels}, 16'h1 << lv);
      fire(ON, 8'h0);
      pulse(16'h0100 << a);
      expect_acc((lv == 3 && ne == 1) ? VEC : NON, 16'(22 + 2 * a), 30);
      rdr(4'h8, rd);
      chk(rd, (lv == 3 && ne == 1) ? 16'h0 : 16'h0100 << a);
      fire(RV, 8'h0);
      fire(RV, 8'h0);
      wr(4'h8, 16'h0);
      chk({12'h0, in_service_levels}, 16'h0);
    end
    // simultaneous requests: programmed level first, index order on ties
    for (ne = 0; ne < 2; ne++) begin
      a = $urandom_range(7, 0);
      wr(4'h4, 16'hffff);
      wr(4'h5, ne ? 16'hffff : ~(16'h2 << 2 * a));
      wr(4'h0, ~(16'h0101 << a));
      pulse(16'h0101 << a);
      fire(ON, 8'h0);
      expect_acc(VEC, ne ? 16'(6 + 2 * a) : 16'(22 + 2 * a), 40);
      fire(RV, 8'h20);
      expect_acc(VEC, ne ? 16'(22 + 2 * a) : 16'(6 + 2 * a), 40);
      fire(RV, 8'h0);
    end
    // macro service then context switch, each with enable set
    for (k = 0; k < 2; k++) begin
      a = $urandom_range(15, 0);
      slow <= k[0];
      wr(4'h4, 16'haaaa);
      wr(4'h5, 16'haaaa);
      wr(4'h0, ~(16'h1 << a));
      wr(k ? 4'h6 : 4'h7, 16'h1 << a);
      fire(ON, 8'h0);
      pulse(16'h1 << a);
      expect_acc(k ? SWC : MAC, 16'(6 + 2 * a), 40);
      chk({15'h0, global_irq_enable}, k ? 16'h0 : 16'h1);
      chk({12'h0, in_service_levels}, k ? 16'h4 : 16'h0);
      fire(RB, 8'h0);
      chk({12'h0, in_service_levels}, k ? 16'h4 : 16'h0);
      fire(POP, 8'h20);
      chk({8'h0, status_word_low}, 16'h0020);
      fire(k ? RS : RV, 8'h0);
      chk({12'h0, in_service_levels}, 16'h0);
      chk({8'h0, status_word_low}, 16'h0000);
      wr(k ? 4'h6 : 4'h7, 16'h0);
    end
    // both non-maskable sources at once under each ordering
    for (k = 0; k < 2; k++) begin
      wr(4'h9, {15'h0, k[0]});
      run <= 1'b0;
      fire(ON, 8'h0);
      nmi_pin <= 1'b1;
      wdt_nmi_req <= 1'b1;
      @(posedge ref_clk);
      wdt_nmi_req <= 1'b0;
      repeat (6) @(posedge ref_clk);
      run <= 1'b1;
      expect_acc(k ? WDT : PIN, k ? 16'h0004 : 16'h0002, 40);
      chk({15'h0, global_irq_enable}, 16'h0);
      repeat (2) begin
        @(posedge ref_clk);
        wdt_nmi_req <= 1'b1;
        @(posedge ref_clk);
        wdt_nmi_req <= 1'b0;
      end
      expect_acc(NON, 16'h0, 20);
      fire(RV, 8'h0);
      expect_acc(WDT, 16'h0004, 40);
      fire(RV, 8'h0);
      expect_acc(k ? PIN : NON, 16'h0002, 40);
      nmi_pin <= 1'b0;
      if (k)
        fire(RV, 8'h0);
    end
    final_report();
  end
endmodule
`default_nettype wire
